// ---- rtl/fpq_defines.vh ----
// Function
// - host: enter sequence then protect algorithm locks
// - host: exit secure mode after lock and verify
// - both: write only with ce, we low, oe high
// - both: program needs preceding unlock cycles
// - both: 98h at word 55h enters query
// - host: reset command leaves query mode
`ifndef FPQ_DEFINES_VH
`define FPQ_DEFINES_VH
`define FPQ_ADDR_UNLOCK1   21'h000555
`define FPQ_ADDR_UNLOCK2   21'h0002aa
`define FPQ_ADDR_QUERY     21'h000055
`define FPQ_DATA_UNLOCK1   16'h00aa
`define FPQ_DATA_UNLOCK2   16'h0055
`define FPQ_CMD_QUERY      16'h0098
`define FPQ_CMD_RESET      16'h00f0
`define FPQ_CMD_SEC_ENTER  16'h0088
`define FPQ_CMD_SEC_EXIT   16'h0090
`define FPQ_CMD_SEC_EXIT2  16'h0000
`define FPQ_CMD_PROGRAM    16'h00a0
`define FPQ_QRY_ADDR0      21'h000010
`define FPQ_QRY_Q          16'h0051
`define FPQ_QRY_R          16'h0052
`define FPQ_QRY_Y          16'h0059
`define FPQ_LOCK_BIT       7
`define FPQ_T_SETUP_NS     30
`define FPQ_T_PULSE_NS     40
`define FPQ_T_ACCESS_NS    90
`define FPQ_CLK_NS         10
`define FPQ_ACCESS_PAD     2
`endif

// ---- rtl/fpq_bus_cycle.v ----
`timescale 1ns/1ps
`include "fpq_defines.vh"
// one parallel bus cycle: write or read with fixed strobe timing
module fpq_bus_cycle (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        start,
  input  wire        isWrite,
  input  wire [20:0] addrIn,
  input  wire [15:0] dataIn,
  input  wire [15:0] pinDataIn,
  output reg         busy,
  output reg         done,
  output reg  [15:0] readData,
  output reg  [20:0] flashAddr,
  output reg  [15:0] flashDataOut,
  output reg         flashDataOe_n,
  output reg         flashCe_n,
  output reg         flashOe_n,
  output reg         flashWe_n
);
  localparam integer SETUP_INT  = (`FPQ_T_SETUP_NS + `FPQ_CLK_NS - 1) / `FPQ_CLK_NS;
  localparam integer PULSE_INT  = (`FPQ_T_PULSE_NS + `FPQ_CLK_NS - 1) / `FPQ_CLK_NS;
  localparam integer ACCESS_INT = (`FPQ_T_ACCESS_NS + `FPQ_CLK_NS - 1) / `FPQ_CLK_NS + `FPQ_ACCESS_PAD;
  localparam [7:0]   SETUP_CYC  = SETUP_INT[7:0];
  localparam [7:0]   PULSE_CYC  = PULSE_INT[7:0];
  localparam [7:0]   ACCESS_CYC = ACCESS_INT[7:0];
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_SETUP = 2'h1;
  localparam [1:0] S_STROBE = 2'h2;
  localparam [1:0] S_END = 2'h3;
  reg [1:0] state;
  reg [7:0] count;
  reg       writing;
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= S_IDLE;
      count <= 8'h00;
      writing <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      readData <= 16'h0000;
      flashAddr <= 21'h000000;
      flashDataOut <= 16'h0000;
      flashDataOe_n <= 1'b1;
      flashCe_n <= 1'b1;
      flashOe_n <= 1'b1;
      flashWe_n <= 1'b1;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (start)
          begin
            busy <= 1'b1;
            writing <= isWrite;
            flashAddr <= addrIn;
            flashDataOut <= dataIn;
            flashDataOe_n <= ~isWrite;
            flashCe_n <= 1'b0;
            count <= SETUP_CYC;
            state <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          if (count > 8'h01)
            count <= count - 8'h01;
          else
          begin
            // write: ce low, we low, oe high
            flashWe_n <= ~writing;
            flashOe_n <= writing;
            count <= writing ? PULSE_CYC : ACCESS_CYC;
            state <= S_STROBE;
          end
        end
        S_STROBE:
        begin
          if (count > 8'h01)
            count <= count - 8'h01;
          else
          begin
            if (!writing)
              readData <= pinDataIn;
            flashWe_n <= 1'b1;
            flashOe_n <= 1'b1;
            state <= S_END;
          end
        end
        S_END:
        begin
          flashCe_n <= 1'b1;
          flashDataOe_n <= 1'b1;
          busy <= 1'b0;
          done <= 1'b1;
          state <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule

// ---- rtl/fpq_host.v ----
`timescale 1ns/1ps
`include "fpq_defines.vh"
// host sequencer: runs reads, single-write query and reset, and unlock-prefixed command sequences on the flash pins
module fpq_host (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        opStart,
  input  wire [2:0]  opCode,
  input  wire [20:0] opAddr,
  input  wire [15:0] opData,
  input  wire [15:0] flashDataIn,
  output reg         opBusy,
  output reg         opDone,
  output reg  [15:0] opReadData,
  output reg         lockIndicator,
  output reg         queryMode,
  output reg         secureMode,
  output wire [20:0] flashAddr,
  output wire [15:0] flashDataOut,
  output wire        flashDataOe_n,
  output wire        flashCe_n,
  output wire        flashOe_n,
  output wire        flashWe_n
);
  localparam [2:0] OP_READ      = 3'h0;
  localparam [2:0] OP_QUERY     = 3'h1;
  localparam [2:0] OP_RESET     = 3'h2;
  localparam [2:0] OP_SEC_ENTER = 3'h3;
  localparam [2:0] OP_SEC_EXIT  = 3'h4;
  localparam [2:0] OP_PROGRAM   = 3'h5;
  localparam [2:0] OP_LOCK_READ = 3'h6;
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_ISSUE = 2'h1;
  localparam [1:0] S_WAIT = 2'h2;
  reg  [1:0]  state;
  reg  [2:0]  op;
  reg  [2:0]  step;
  reg  [20:0] addr;
  reg  [15:0] data;
  reg  [15:0] pinSync1;
  reg  [15:0] pinSync2;
  reg         cycStart;
  reg         cycWrite;
  reg  [20:0] cycAddr;
  reg  [15:0] cycData;
  wire        cycBusy;
  wire        cycDone;
  wire [15:0] cycRead;
  // number of bus cycles in each operation
  function [2:0] opLength;
    input [2:0] code;
    begin
      case (code)
        OP_QUERY:     opLength = 3'h1;
        OP_RESET:     opLength = 3'h1;
        OP_SEC_ENTER: opLength = 3'h3;
        OP_SEC_EXIT:  opLength = 3'h4;
        OP_PROGRAM:   opLength = 3'h4;
        default:      opLength = 3'h1;
      endcase
    end
  endfunction
  // the step after this one, and whether the current step ends the operation
  wire [2:0]  nextStep = step + 3'h1;
  wire        lastStep = nextStep >= opLength(op);
  // data pins cross into the clock domain through two flops
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinSync1 <= 16'h0000;
      pinSync2 <= 16'h0000;
    end
    else
    begin
      pinSync1 <= flashDataIn;
      pinSync2 <= pinSync1;
    end
  end
  fpq_bus_cycle u_cycle (
    .core_clk      (core_clk),
    .reset_n       (reset_n),
    .start         (cycStart),
    .isWrite       (cycWrite),
    .addrIn        (cycAddr),
    .dataIn        (cycData),
    .pinDataIn     (pinSync2),
    .busy          (cycBusy),
    .done          (cycDone),
    .readData      (cycRead),
    .flashAddr     (flashAddr),
    .flashDataOut  (flashDataOut),
    .flashDataOe_n (flashDataOe_n),
    .flashCe_n     (flashCe_n),
    .flashOe_n     (flashOe_n),
    .flashWe_n     (flashWe_n)
  );
  // cycle list for the current step
  always @*
  begin
    cycWrite = 1'b1;
    cycAddr = `FPQ_ADDR_UNLOCK1;
    cycData = `FPQ_DATA_UNLOCK1;
    case (op)
      OP_QUERY:
      begin
        cycAddr = `FPQ_ADDR_QUERY;
        cycData = `FPQ_CMD_QUERY;
      end
      OP_RESET:
      begin
        cycAddr = addr;
        cycData = `FPQ_CMD_RESET;
      end
      OP_SEC_ENTER, OP_SEC_EXIT, OP_PROGRAM:
      begin
        // unlock pair precedes the enter, exit and program commands
        if (step == 3'h1)
        begin
          cycAddr = `FPQ_ADDR_UNLOCK2;
          cycData = `FPQ_DATA_UNLOCK2;
        end
        else if (step == 3'h2)
        begin
          cycAddr = `FPQ_ADDR_UNLOCK1;
          cycData = (op == OP_SEC_ENTER) ? `FPQ_CMD_SEC_ENTER :
                    (op == OP_SEC_EXIT) ? `FPQ_CMD_SEC_EXIT : `FPQ_CMD_PROGRAM;
        end
        else if (step == 3'h3)
        begin
          cycAddr = (op == OP_PROGRAM) ? addr : 21'h000000;
          cycData = (op == OP_PROGRAM) ? data : `FPQ_CMD_SEC_EXIT2;
        end
      end
      default:
      begin
        cycWrite = 1'b0;
        cycAddr = addr;
        cycData = 16'h0000;
      end
    endcase
  end
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= S_IDLE;
      op <= OP_READ;
      step <= 3'h0;
      addr <= 21'h000000;
      data <= 16'h0000;
      cycStart <= 1'b0;
      opBusy <= 1'b0;
      opDone <= 1'b0;
      opReadData <= 16'h0000;
      lockIndicator <= 1'b0;
      queryMode <= 1'b0;
      secureMode <= 1'b0;
    end
    else
    begin
      cycStart <= 1'b0;
      opDone <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (opStart)
          begin
            op <= opCode;
            addr <= opAddr;
            data <= opData;
            step <= 3'h0;
            opBusy <= 1'b1;
            state <= S_ISSUE;
          end
        end
        S_ISSUE:
        begin
          if (!cycBusy)
          begin
            cycStart <= 1'b1;
            state <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          if (cycDone)
          begin
            if (!lastStep)
            begin
              step <= nextStep;
              state <= S_ISSUE;
            end
            else
            begin
              opReadData <= cycRead;
              case (op)
                OP_LOCK_READ:
                  lockIndicator <= cycRead[`FPQ_LOCK_BIT];
                OP_QUERY:
                  queryMode <= 1'b1;
                OP_RESET:
                  queryMode <= 1'b0;
                OP_SEC_ENTER:
                  secureMode <= 1'b1;
                OP_SEC_EXIT:
                  secureMode <= 1'b0;
                default:
                  lockIndicator <= lockIndicator;
              endcase
              opBusy <= 1'b0;
              opDone <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule

// ---- sim/fpq_host_chk.sv ----
`timescale 1ns/1ps
`include "fpq_defines.vh"
module fpq_host_chk (
  input wire        core_clk,
  input wire        reset_n,
  input wire        opStart,
  input wire [2:0]  opCode,
  input wire        opBusy,
  input wire [20:0] flashAddr,
  input wire [15:0] flashDataOut,
  input wire        flashDataOe_n,
  input wire        flashCe_n,
  input wire        flashOe_n,
  input wire        flashWe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire take = opStart && !opBusy;
  wire wr = !flashWe_n;
  a_write_gate: assert property (
    wr |-> !flashCe_n && flashOe_n)
    else $error("write strobe without chip enable or with output enable");
  a_no_contention: assert property (
    !flashOe_n |-> flashDataOe_n && flashWe_n)
    else $error("read strobe while host drives data");
  a_write_held: assert property (
    wr && $past(wr) |-> $stable(flashAddr) && $stable(flashDataOut))
    else $error("address or data moved inside write pulse");
  a_query_cmd: assert property (
    take && opCode == 3'h1 |-> ##[1:40] (wr && flashAddr == 21'h000055 && flashDataOut == 16'h0098))
    else $error("query command not written");
  a_reset_cmd: assert property (
    take && opCode == 3'h2 |-> ##[1:40] (wr && flashDataOut == `FPQ_CMD_RESET))
    else $error("reset command not written");
  a_unlock_first: assert property (
    take && opCode == 3'h5 |-> ##[1:20] (wr && flashAddr == `FPQ_ADDR_UNLOCK1 && flashDataOut == `FPQ_DATA_UNLOCK1))
    else $error("program without leading unlock write");
  a_enter_seq: assert property (
    take && opCode == 3'h3 |-> ##[20:80] (wr && flashDataOut == `FPQ_CMD_SEC_ENTER))
    else $error("enter command not third write");
  a_exit_seq: assert property (
    take && opCode == 3'h4 |-> ##[20:80] (wr && flashDataOut == `FPQ_CMD_SEC_EXIT))
    else $error("exit command not written after unlocks");
endmodule
bind fpq_host fpq_host_chk chk (.core_clk(core_clk), .reset_n(reset_n), .opStart(opStart), .opCode(opCode),
  .opBusy(opBusy), .flashAddr(flashAddr), .flashDataOut(flashDataOut), .flashDataOe_n(flashDataOe_n),
  .flashCe_n(flashCe_n), .flashOe_n(flashOe_n), .flashWe_n(flashWe_n));

// ---- sim/fpq_flash_model.sv ----
`timescale 1ns/1ps
`include "fpq_defines.vh"
module fpq_flash_model #(
  parameter        FACTORY_LOCKED = 1,
  parameter [15:0] MEM_BASE       = 16'h5a00,
  parameter [15:0] SN_BASE        = 16'h3c00
) (
  input  wire        hwReset_n,
  input  wire        highVoltage,
  input  wire        bootGuard_n,
  input  wire        supplyOk,
  input  wire [20:0] addr,
  input  wire [15:0] dq,
  input  wire        ce_n,
  input  wire        oe_n,
  input  wire        we_n,
  output wire [15:0] devOut
);
  reg [15:0] mem [0:31];
  reg [15:0] secMem [0:15];
  wire [15:0] rd;
  wire [15:0] qryData;
  reg [15:0] rdLast;
  reg [2:0]  step;
  reg        query;
  reg        secure;
  integer    i;
  wire boot  = addr[20:15] == 6'h00;
  wire outer = addr[20:13] == 8'h00;
  initial
  begin
    rdLast = 16'h0000;
    for (i = 0; i < 32; i = i + 1)
      mem[i] = MEM_BASE | i;
    for (i = 0; i < 16; i = i + 1)
      secMem[i] = SN_BASE | i;
  end
  // continuous so a word written under a held address shows at once
  assign qryData = addr == 21'h10 ? `FPQ_QRY_Q : addr == 21'h11 ? `FPQ_QRY_R :
                   addr == 21'h12 ? `FPQ_QRY_Y : 16'h0000;
  assign rd = query ? qryData :
              (secure && boot) ? secMem[addr[3:0]] :
              secure ? (FACTORY_LOCKED ? 16'h0080 : 16'h0000) :
              mem[addr[4:0]];
  // released bus shows the inverse of the last value
  always @(posedge oe_n)
    rdLast <= rd;
  assign devOut = (!ce_n && !oe_n) ? rd : ~rdLast;
  always @(posedge we_n or negedge hwReset_n)
    if (!hwReset_n)
    begin
      step   <= 3'h0;
      query  <= 1'b0;
      secure <= 1'b0;
    end
    else if (!supplyOk)
    begin
      step  <= 3'h0;
      query <= 1'b0;
    end
    else if (!ce_n && oe_n)
    begin
      step <= 3'h0;
      if (dq == `FPQ_CMD_RESET)
        query <= 1'b0;
      else if (step == 3'h3 && secure)
      begin
        if (!FACTORY_LOCKED && boot)
          secMem[addr[3:0]] <= dq;
      end
      else if (step == 3'h3 && !(boot && !highVoltage) && !(outer && !bootGuard_n))
        mem[addr[4:0]] <= dq;
      else if (step == 3'h4 && dq == `FPQ_CMD_SEC_EXIT2)
        secure <= 1'b0;
      else if (dq == 16'h0098 && addr == 21'h55)
        query <= 1'b1;
      else if (step == 3'h0 && addr == `FPQ_ADDR_UNLOCK1 && dq == `FPQ_DATA_UNLOCK1)
        step <= 3'h1;
      else if (step == 3'h1 && addr == `FPQ_ADDR_UNLOCK2 && dq == `FPQ_DATA_UNLOCK2)
        step <= 3'h2;
      else if (step == 3'h2)
      begin
        step <= dq == `FPQ_CMD_PROGRAM ? 3'h3 : dq == `FPQ_CMD_SEC_EXIT ? 3'h4 : 3'h0;
        if (dq == `FPQ_CMD_SEC_ENTER)
          secure <= 1'b1;
      end
    end
endmodule

// ---- sim/flash_protect_and_query_modes_bench.sv ----
`timescale 1ns/1ps
module flash_protect_and_query_modes_bench;
  localparam [15:0] MB = 16'h5a00;
  localparam [15:0] SB = 16'h3c00;
  reg         core_clk = 0, reset_n = 0, opStart = 0, hwReset_n = 0, highVoltage = 0, bootGuard_n = 1, supplyOk = 1;
  reg  [2:0]  opCode = 3'h0;
  reg  [20:0] opAddr = 21'h0;
  reg  [15:0] opData = 16'h0, rdv;
  wire        opBusy, opDone, lockIndicator, queryMode, secureMode, flashDataOe_n, flashCe_n, flashOe_n, flashWe_n;
  wire [15:0] opReadData, flashDataOut, devOut, dq;
  wire [20:0] flashAddr;
  integer     n_mismatch = 0, checked = 0;
  assign dq = !flashDataOe_n ? flashDataOut : devOut;
  always #5 core_clk = ~core_clk;
  fpq_host uut (.core_clk(core_clk), .reset_n(reset_n), .opStart(opStart), .opCode(opCode), .opAddr(opAddr),
    .opData(opData), .flashDataIn(dq), .opBusy(opBusy), .opDone(opDone), .opReadData(opReadData),
    .lockIndicator(lockIndicator), .queryMode(queryMode), .secureMode(secureMode), .flashAddr(flashAddr),
    .flashDataOut(flashDataOut), .flashDataOe_n(flashDataOe_n), .flashCe_n(flashCe_n), .flashOe_n(flashOe_n),
    .flashWe_n(flashWe_n));
  fpq_flash_model #(.FACTORY_LOCKED(1), .MEM_BASE(MB), .SN_BASE(SB)) flash (.hwReset_n(hwReset_n),
    .highVoltage(highVoltage), .bootGuard_n(bootGuard_n), .supplyOk(supplyOk), .addr(flashAddr), .dq(dq),
    .ce_n(flashCe_n), .oe_n(flashOe_n), .we_n(flashWe_n), .devOut(devOut));
  task give_verdict;
  begin
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task check(input [8*12-1:0] what, input [15:0] seen, input [15:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task doOp(input [2:0] c, input [20:0] a, input [15:0] d);
    integer k;
  begin
    @(posedge core_clk);
    #1 opStart = 1;
    opCode = c;
    opAddr = a;
    opData = d;
    @(posedge core_clk);
    #1 opStart = 0;
    check("op busy", opBusy, 16'h1);
    for (k = 0; k < 400 && opDone !== 1'b1; k = k + 1)
      #10;
    if (opDone !== 1'b1)
    begin
      n_mismatch = n_mismatch + 1;
      give_verdict;
    end
    else
    begin
      check("op idle", opBusy, 16'h0);
      rdv = opReadData;
    end
  end
  endtask
  task rdChk(input [20:0] a, input [15:0] e);
  begin
    doOp(3'h0, a, 16'h0);
    check("read data", rdv, e);
  end
  endtask
  // programs a word, then expects new data or the untouched initial pattern
  task progChk(input [20:0] a, input [15:0] d, input chg);
  begin
    doOp(3'h5, a, d);
    rdChk(a, chg ? d : MB | {11'h0, a[4:0]});
  end
  endtask
  task scen_query;
  begin
    doOp(3'h1, 21'h55, 16'h0);
    check("query mode", queryMode, 16'h1);
    rdChk(21'h10, 16'h0051);
    rdChk(21'h11, 16'h0052);
    rdChk(21'h12, 16'h0059);
    doOp(3'h2, 21'h0, 16'h0);
    check("query mode", queryMode, 16'h0);
    rdChk(21'h12, MB | 16'h0012);
  end
  endtask
  task scen_protect;
  begin
    progChk(21'h10000, 16'h1234, 1);
    progChk(21'h00005, 16'h1111, 0);
    highVoltage = 1;
    progChk(21'h00004, 16'h2222, 1);
    bootGuard_n = 0;
    progChk(21'h00006, 16'h3333, 0);
    progChk(21'h04007, 16'h4444, 1);
    bootGuard_n = 1;
    highVoltage = 0;
    progChk(21'h04008, 16'h5555, 0);
  end
  endtask
  task scen_secure;
  begin
    doOp(3'h3, 21'h0, 16'h0);
    check("secure mode", secureMode, 16'h1);
    rdChk(21'h2, SB | 16'h0002);
    doOp(3'h6, 21'h10000, 16'h0);
    check("lock bit", lockIndicator, 16'h1);
    doOp(3'h5, 21'h2, 16'hbeef);
    rdChk(21'h2, SB | 16'h0002);
    doOp(3'h4, 21'h0, 16'h0);
    check("secure mode", secureMode, 16'h0);
    rdChk(21'h2, MB | 16'h0002);
    doOp(3'h3, 21'h0, 16'h0);
    #1 hwReset_n = 0;
    #20 hwReset_n = 1;
    rdChk(21'h2, MB | 16'h0002);
  end
  endtask
  task scen_lockout;
  begin
    supplyOk = 0;
    doOp(3'h5, 21'h10001, 16'h6666);
    supplyOk = 1;
    rdChk(21'h10001, MB | 16'h0001);
    progChk(21'h10001, 16'h7777, 1);
  end
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    #1 reset_n = 1;
    hwReset_n = 1;
    scen_query;
    scen_protect;
    scen_secure;
    scen_lockout;
    give_verdict;
  end
endmodule
